// >>> src/fault_sup_pkg.sv
/*
  Constants, states and configuration codes for the power stage fault supervisor.
  Assumes a single 40 MHz clock and comparator levels already synchronous to it.
*/
package fault_sup_pkg;
  localparam int CLK_MHZ = 40;
  // Short check length per microfarad of output filter capacitance, in microseconds.
  localparam int PSC_US_PER_UF = 15000;
  localparam int PSC_CYC_PER_UF = PSC_US_PER_UF * CLK_MHZ;
  // Least hold-off from shutdown fall to reset rise, in microseconds.
  localparam int OLP_HOLD_US = 4000;
  localparam int OLP_HOLD_CYC = OLP_HOLD_US * CLK_MHZ;
  localparam int CAP_UF_W = 4;
  localparam int CNT_W = 24;

  localparam logic [1:0] CFG_BRIDGED = 2'h0;
  localparam logic [1:0] CFG_PARALLEL = 2'h1;
  localparam logic [1:0] CFG_SINGLE = 2'h2;

  localparam logic [3:0] HB_NONE = 4'h0;
  localparam logic [3:0] HB_ALL = 4'hF;
  localparam logic [3:0] HB_AB = 4'h3;
  localparam logic [3:0] HB_BD = 4'hA;
  localparam logic [3:0] HB_AD = 4'h9;

  typedef enum logic [4:0] {
    ST_POWER = 5'b0_0001,
    ST_GND = 5'b0_0010,
    ST_SUP = 5'b0_0100,
    ST_SHORT = 5'b0_1000,
    ST_RUN = 5'b1_0000
  } startup_t;
endpackage

// >>> src/power_stage_fault_supervisor.sv
/*
  Fault supervisor for four half-bridges: supply, overload, bootstrap and thermal checks,
  startup pin short check, and open-drain status pins.
  Assumes all inputs are synchronous to MCLK; the analog comparators are outside.
*/
// What this block does
// [R1] Hi-Z outputs until all supplies are good.
// [R2] Controller may hold reset low at power-up.
// [R3] Shutdown pin low on any shutting fault.
// [R4] Warnings low above 125 and 100 degrees.
// [R5] Three status pins encode faults and temperature.
// [R6] Reset low forces shutdown pin high.
// [R7] Fault at once gives Hi-Z and shutdown.
// [R8] Auto recovery except overload and overtemperature.
// [R9] Local error disables configuration-dependent half-bridge group.
// [R10] Bootstrap undervoltage disables only its half-bridge.
// [R11] Short check runs once at core power-up.
// [R12] Found short holds Hi-Z until removed.
// [R13] Check ground shorts first, then supply.
// [R14] Check length bounded per microfarad of filter.
// [R15] During check shutdown low, reset ignored.
// [R16] Short check skipped in single-ended configuration.
// [R17] Three-level variant latches shutdown above 155.
// [R18] Two-level variant single warning, same latch.
// [R19] Each supply monitored; any drop shuts down.
// [R20] Power-on reset clears overload, holds inactive.
// [R21] Reset low gives Hi-Z, bridged pulldowns on.
// [R22] Overload clears on reset rise after 4 ms.
`timescale 1ns/100ps
module power_stage_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int OLP_HOLD = OLP_HOLD_CYC,
  parameter int PSC_PER_UF = PSC_CYC_PER_UF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic [1:0] CONFIG_SEL,
  input wire logic THREE_LEVEL,
  input wire logic [CAP_UF_W-1:0] FILTER_CAP_UF,
  input wire logic CORE_SUPPLY_OK,
  input wire logic [3:0] GATE_DRIVE_SUPPLY_OK,
  input wire logic [3:0] BOOTSTRAP_OK,
  input wire logic [3:0] OVERLOAD_DET,
  input wire logic TEMP_ABOVE_100,
  input wire logic TEMP_ABOVE_125,
  input wire logic TEMP_ABOVE_155,
  input wire logic SHORT_TO_GND,
  input wire logic SHORT_TO_SUPPLY,
  output logic [3:0] HB_ENABLE,
  output logic [3:0] HB_PULLDOWN,
  output logic FAULT_SHUTDOWN_N_O,
  output logic FAULT_SHUTDOWN_N_OE,
  output logic THERMAL_WARN_N_O,
  output logic THERMAL_WARN_N_OE,
  output logic THERMAL_WARN_LO_N_O,
  output logic THERMAL_WARN_LO_N_OE,
  output logic THERMAL_WARN_HI_N_O,
  output logic THERMAL_WARN_HI_N_OE,
  output logic SHORT_CHECK_BUSY
);

  // Group of half-bridges switched off for a local error in one half-bridge.
  function automatic logic [3:0] group_off(input logic [1:0] cfg, input logic [3:0] err);
    logic [3:0] g;
    g = HB_NONE;
    if (cfg == CFG_PARALLEL) begin
      if (err != HB_NONE) begin
        g = HB_ALL;
      end
    end else begin
      if (err[0]) begin
        g = g | HB_AB;
      end
      if (err[1]) begin
        g = g | ((cfg == CFG_SINGLE) ? HB_AB : HB_AD);
      end
      if (err[2] | err[3]) begin
        g = g | HB_BD;
      end
    end
    return g;
  endfunction

  // Warning pin enable: pulled low only when hot and the pin belongs to the fitted variant.
  function automatic logic warn_oe(input logic hot, input logic fitted);
    return ~(hot & fitted);
  endfunction

  startup_t state_ff, nxt_state;
  logic [CNT_W-1:0] chk_cnt_ff;
  logic [CNT_W-1:0] hold_cnt_ff;
  logic [3:0] olp_ff;
  logic ote_ff;
  logic reset_n_d_ff;
  logic supplies_ok;
  logic core_d_ff;
  logic [CNT_W-1:0] chk_len;
  logic [3:0] off_mask;
  logic fault_any;
  logic reset_rise;
  logic olp_clear;

  assign supplies_ok = CORE_SUPPLY_OK & (&GATE_DRIVE_SUPPLY_OK); // [R19]
  assign chk_len = CNT_W'(PSC_PER_UF) * CNT_W'(FILTER_CAP_UF);
  assign reset_rise = RESET_N & ~reset_n_d_ff;
  // A too-early reset edge is refused, so a short reset pulse cannot cut the cool-down time.
  assign olp_clear = reset_rise && hold_cnt_ff >= CNT_W'(OLP_HOLD) && state_ff == ST_RUN;

  // A pin already high at release reads as a rise; it only clears an overload that waited long enough.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      reset_n_d_ff <= 1'b0;
    end else begin
      reset_n_d_ff <= RESET_N;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      core_d_ff <= 1'b0;
    end else begin
      core_d_ff <= CORE_SUPPLY_OK;
    end
  end

  // The short check is tied to the core supply rising, never to the reset pin.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWER: begin
        if (CORE_SUPPLY_OK & ~core_d_ff) begin // [R11]
          nxt_state = (CONFIG_SEL == CFG_SINGLE) ? ST_RUN : ST_GND; // [R16]
        end
      end
      ST_GND: begin
        if (SHORT_TO_GND) begin
          nxt_state = ST_SHORT; // [R12]
        end else if (chk_cnt_ff >= (chk_len >> 1)) begin
          nxt_state = ST_SUP; // [R13]
        end
      end
      ST_SUP: begin
        if (SHORT_TO_SUPPLY) begin
          nxt_state = ST_SHORT;
        end else if (chk_cnt_ff >= chk_len) begin // [R14]
          nxt_state = ST_RUN;
        end
      end
      ST_SHORT: begin
        if (~SHORT_TO_GND & ~SHORT_TO_SUPPLY) begin
          nxt_state = ST_RUN; // [R12]
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_POWER;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_ff <= ST_POWER;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || state_ff == ST_POWER || state_ff == ST_SHORT) begin
      chk_cnt_ff <= '0;
    end else if (state_ff != ST_RUN) begin
      chk_cnt_ff <= chk_cnt_ff + 1'b1;
    end
  end

  // Overload latch per half-bridge, cleared by power-on reset or a late enough reset rise.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      olp_ff <= HB_NONE; // [R20]
    end else if (olp_clear) begin
      olp_ff <= OVERLOAD_DET; // [R22]
    end else begin
      olp_ff <= olp_ff | OVERLOAD_DET; // [R8]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ote_ff <= 1'b0;
    end else if (TEMP_ABOVE_155) begin
      ote_ff <= 1'b1; // [R17] [R18]
    end else if (~RESET_N && state_ff == ST_RUN) begin
      ote_ff <= 1'b0;
    end
  end

  // Counts time since the overload latched, which is when the shutdown pin fell.
  // The reset pin forces that pin high, so the pin itself cannot time the hold-off.
  always_ff @(posedge MCLK) begin
    if (RST || olp_ff == HB_NONE) begin
      hold_cnt_ff <= '0;
    end else if (hold_cnt_ff < CNT_W'(OLP_HOLD)) begin
      hold_cnt_ff <= hold_cnt_ff + 1'b1; // [R22]
    end
  end

  assign off_mask = group_off(CONFIG_SEL, olp_ff) | ~BOOTSTRAP_OK; // [R9] [R10]
  assign fault_any = ~supplies_ok | ote_ff | (|olp_ff) | (~BOOTSTRAP_OK != HB_NONE);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      HB_ENABLE <= HB_NONE;
    end else if (~supplies_ok || state_ff != ST_RUN || ote_ff) begin
      HB_ENABLE <= HB_NONE; // [R1] [R7] [R12] [R19]
    end else if (~RESET_N) begin
      HB_ENABLE <= HB_NONE; // [R21]
    end else begin
      HB_ENABLE <= ~off_mask; // [R7]
    end
  end

  // Weak pulldowns only charge the bootstrap capacitors; single-ended outputs stay floating.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      HB_PULLDOWN <= HB_NONE;
    end else if (~supplies_ok || state_ff != ST_RUN || ote_ff || RESET_N) begin
      HB_PULLDOWN <= HB_NONE;
    end else begin
      HB_PULLDOWN <= (CONFIG_SEL == CFG_SINGLE) ? HB_NONE : HB_ALL; // [R2] [R21]
    end
  end

  // Open-drain pins: enable low means the pin is pulled low.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SHORT_CHECK_BUSY <= 1'b0;
    end else begin
      SHORT_CHECK_BUSY <= (state_ff != ST_RUN) && (state_ff != ST_POWER);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      FAULT_SHUTDOWN_N_OE <= 1'b0;
    end else begin
      if (state_ff != ST_RUN && state_ff != ST_POWER) begin
        FAULT_SHUTDOWN_N_OE <= 1'b0; // [R15]
      end else if (~RESET_N) begin
        FAULT_SHUTDOWN_N_OE <= 1'b1; // [R6]
      end else begin
        FAULT_SHUTDOWN_N_OE <= ~fault_any; // [R3] [R5]
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      FAULT_SHUTDOWN_N_O <= 1'b1;
    end else begin
      FAULT_SHUTDOWN_N_O <= FAULT_SHUTDOWN_N_OE; // [R3]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      THERMAL_WARN_N_OE <= 1'b1;
      THERMAL_WARN_LO_N_OE <= 1'b1;
      THERMAL_WARN_HI_N_OE <= 1'b1;
    end else begin
      THERMAL_WARN_N_OE <= warn_oe(TEMP_ABOVE_125, ~THREE_LEVEL); // [R18]
      THERMAL_WARN_LO_N_OE <= warn_oe(TEMP_ABOVE_100, THREE_LEVEL); // [R4] [R17]
      THERMAL_WARN_HI_N_OE <= warn_oe(TEMP_ABOVE_125, THREE_LEVEL); // [R4] [R5]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      THERMAL_WARN_N_O <= 1'b0;
      THERMAL_WARN_LO_N_O <= 1'b0;
      THERMAL_WARN_HI_N_O <= 1'b0;
    end else begin
      THERMAL_WARN_N_O <= 1'b0;
      THERMAL_WARN_LO_N_O <= 1'b0;
      THERMAL_WARN_HI_N_O <= 1'b0;
    end
  end

endmodule // power_stage_fault_supervisor

// >>> verif/fault_sup_assertions.sv
/* Port checker for the fault supervisor.
   Assumes it is bound onto the top module and sees its ports only. */
`timescale 1ns/100ps
module fault_sup_assertions
  import fault_sup_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic [1:0] CONFIG_SEL,
  input wire logic THREE_LEVEL,
  input wire logic CORE_SUPPLY_OK,
  input wire logic [3:0] GATE_DRIVE_SUPPLY_OK,
  input wire logic TEMP_ABOVE_100,
  input wire logic TEMP_ABOVE_125,
  input wire logic TEMP_ABOVE_155,
  input wire logic [3:0] HB_ENABLE,
  input wire logic [3:0] HB_PULLDOWN,
  input wire logic FAULT_SHUTDOWN_N_OE,
  input wire logic THERMAL_WARN_N_OE,
  input wire logic THERMAL_WARN_LO_N_OE,
  input wire logic THERMAL_WARN_HI_N_OE,
  input wire logic SHORT_CHECK_BUSY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire uv = !CORE_SUPPLY_OK || GATE_DRIVE_SUPPLY_OK != HB_ALL;
  a_uv_hiz: assert property (uv |=> HB_ENABLE == HB_NONE) else $error("no Hi-Z on low supply");
  a_uv_shut: assert property (uv && RESET_N |=> !FAULT_SHUTDOWN_N_OE) else $error("no shutdown");
  // Four cycles of quiet reset keep the startup states out of the window.
  a_reset_sd: assert property ((!RESET_N && !SHORT_CHECK_BUSY) [*4] |-> FAULT_SHUTDOWN_N_OE)
    else $error("shutdown not forced high");
  a_reset_hiz: assert property (!RESET_N |=> HB_ENABLE == HB_NONE) else $error("switching in reset");
  a_single_pd: assert property (CONFIG_SEL == CFG_SINGLE |=> HB_PULLDOWN == HB_NONE) else $error("pulldown");
  a_busy_hold: assert property (SHORT_CHECK_BUSY |-> HB_ENABLE == HB_NONE && !FAULT_SHUTDOWN_N_OE)
    else $error("check not quiet");
  a_warn_three: assert property (THREE_LEVEL |=> THERMAL_WARN_N_OE &&
    THERMAL_WARN_LO_N_OE == !$past(TEMP_ABOVE_100) && THERMAL_WARN_HI_N_OE == !$past(TEMP_ABOVE_125))
    else $error("three level warn");
  a_warn_two: assert property (!THREE_LEVEL |=> THERMAL_WARN_LO_N_OE && THERMAL_WARN_HI_N_OE &&
    THERMAL_WARN_N_OE == !$past(TEMP_ABOVE_125)) else $error("two level warn");
  a_ote_shut: assert property (TEMP_ABOVE_155 ##0 RESET_N [*3] |->
    HB_ENABLE == HB_NONE && !FAULT_SHUTDOWN_N_OE) else $error("no thermal shutdown");
  c_check: cover property ($rose(SHORT_CHECK_BUSY));
  c_ote: cover property (TEMP_ABOVE_155 ##2 HB_ENABLE == HB_NONE);
  c_group: cover property (RESET_N && HB_ENABLE == ~HB_AB);
endmodule // fault_sup_assertions
bind power_stage_fault_supervisor fault_sup_assertions fault_sup_assertions_inst (.*);

// >>> verif/ctrl_model.sv
/* Controller model: owns the reset pin and watches the shutdown pin.
   Assumes a pull-up on the shutdown pin, so its level equals the output enable. */
`timescale 1ns/100ps
module ctrl_model #(
  parameter int HOLD = 20
) (
  input wire logic clk,
  input wire logic sd_oe,
  input wire logic low_req,
  output logic rst_n
);
  logic sd_q = 1'b1;
  int cnt = 0;
  initial rst_n = 1'b0;
  always @(posedge clk) begin
    sd_q <= sd_oe;
    cnt <= (sd_q && !sd_oe) ? 0 : cnt + 1;
    if (low_req)
      rst_n <= 1'b0;
    else if (cnt > HOLD)
      rst_n <= 1'b1;
  end
endmodule // ctrl_model

// >>> verif/tb.sv
/* Bench for the fault supervisor: startup cases, then a table of steady cases, then latch and supply cases.
   Assumes the controller model drives the reset pin. */
`timescale 1ns/100ps
module tb
  import fault_sup_pkg::*;
;
  typedef struct packed {logic [1:0] cfg; logic [2:0] tmp; logic [3:0] ovl, bst, hb, st;} row_t;
  localparam row_t ROWS [10] = '{'{CFG_BRIDGED, 3'h4, 4'h0, 4'h0, HB_ALL, 4'hF},
    '{CFG_BRIDGED, 3'h6, 4'h0, 4'h0, HB_ALL, 4'hB}, '{CFG_BRIDGED, 3'h7, 4'h0, 4'h0, HB_ALL, 4'h9},
    '{CFG_BRIDGED, 3'h3, 4'h0, 4'h0, HB_ALL, 4'hE}, '{CFG_BRIDGED, 3'h4, 4'h1, 4'h0, ~HB_AB, 4'h7},
    '{CFG_BRIDGED, 3'h4, 4'h2, 4'h0, ~HB_AD, 4'h7}, '{CFG_BRIDGED, 3'h4, 4'h4, 4'h0, ~HB_BD, 4'h7},
    '{CFG_PARALLEL, 3'h4, 4'h8, 4'h0, HB_NONE, 4'h7}, '{CFG_SINGLE, 3'h4, 4'h2, 4'h0, ~HB_AB, 4'h7},
    '{CFG_BRIDGED, 3'h4, 4'h0, 4'h4, 4'hB, 4'h7}};
  logic MCLK = 1'b0, RST = 1'b1, RESET_N, THREE_LEVEL = 1'b1, CORE_SUPPLY_OK = 1'b1, low_req = 1'b1;
  logic TEMP_ABOVE_100 = 1'b0, TEMP_ABOVE_125 = 1'b0, TEMP_ABOVE_155 = 1'b0;
  logic SHORT_TO_GND = 1'b0, SHORT_TO_SUPPLY = 1'b0;
  logic [1:0] CONFIG_SEL = CFG_SINGLE;
  logic [3:0] FILTER_CAP_UF = 4'h2, GATE_DRIVE_SUPPLY_OK = HB_ALL, BOOTSTRAP_OK = HB_ALL, OVERLOAD_DET = 4'h0;
  logic [3:0] HB_ENABLE, HB_PULLDOWN;
  logic FAULT_SHUTDOWN_N_OE, THERMAL_WARN_N_OE, THERMAL_WARN_LO_N_OE, THERMAL_WARN_HI_N_OE, SHORT_CHECK_BUSY;
  logic FAULT_SHUTDOWN_N_O, THERMAL_WARN_N_O, THERMAL_WARN_LO_N_O, THERMAL_WARN_HI_N_O;
  int n_mismatch = 0, num_checks = 0, cycles = 0, i;
  always #12.5 MCLK = ~MCLK;
  power_stage_fault_supervisor #(.OLP_HOLD(20), .PSC_PER_UF(8)) power_stage_fault_supervisor_inst (.*);
  ctrl_model #(.HOLD(20)) ctrl_model_inst (.clk(MCLK), .sd_oe(FAULT_SHUTDOWN_N_OE), .low_req(low_req),
    .rst_n(RESET_N));
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Shutdown stays low a while first, since an early reset rise leaves overload latched.
  task automatic clr;
    cyc(24);
    BOOTSTRAP_OK <= HB_ALL;
    low_req <= 1'b1;
    cyc(3);
    @(negedge MCLK);
    chk("sd_in_reset", FAULT_SHUTDOWN_N_OE, 4'h1);
    chk("pulldown", HB_PULLDOWN, CONFIG_SEL == CFG_SINGLE ? HB_NONE : HB_ALL);
    @(posedge MCLK);
    low_req <= 1'b0;
    for (i = 0; i < 60 && RESET_N !== 1'b1; i++) @(posedge MCLK);
    cyc(3);
    @(negedge MCLK);
    chk("no_recheck", SHORT_CHECK_BUSY, 4'h0);
  endtask
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    cyc(16);
    RST <= 1'b0;
    cyc(20);
    @(negedge MCLK);
    chk("busy_single", SHORT_CHECK_BUSY, 4'h0);
    @(posedge MCLK);
    RST <= 1'b1;
    CONFIG_SEL <= CFG_BRIDGED;
    SHORT_TO_GND <= 1'b1;
    cyc(16);
    RST <= 1'b0;
    cyc(4);
    @(negedge MCLK);
    chk("busy_start", SHORT_CHECK_BUSY, 4'h1);
    cyc(40);
    @(negedge MCLK);
    chk("busy_short", SHORT_CHECK_BUSY, 4'h1);
    @(posedge MCLK);
    SHORT_TO_GND <= 1'b0;
    low_req <= 1'b0;
    for (i = 0; i < 60 && SHORT_CHECK_BUSY !== 1'b0; i++) @(posedge MCLK);
    cyc(3);
    @(negedge MCLK);
    chk("run_after", HB_ENABLE, HB_ALL);
    $display("test startup done");
    foreach (ROWS[r]) begin
      @(posedge MCLK);
      CONFIG_SEL <= ROWS[r].cfg;
      {THREE_LEVEL, TEMP_ABOVE_100, TEMP_ABOVE_125} <= ROWS[r].tmp;
      OVERLOAD_DET <= ROWS[r].ovl;
      BOOTSTRAP_OK <= ~ROWS[r].bst;
      cyc(1);
      OVERLOAD_DET <= 4'h0;
      cyc(3);
      @(negedge MCLK);
      chk("hb_group", HB_ENABLE, ROWS[r].hb);
      chk("status", {FAULT_SHUTDOWN_N_OE, THERMAL_WARN_LO_N_OE, THERMAL_WARN_HI_N_OE, THERMAL_WARN_N_OE},
        ROWS[r].st);
      chk("pin_out", {FAULT_SHUTDOWN_N_O, THERMAL_WARN_LO_N_O, THERMAL_WARN_HI_N_O, THERMAL_WARN_N_O},
        {ROWS[r].st[3], 3'h0});
      clr;
      $display("test row %0d done", r);
    end
    @(posedge MCLK);
    TEMP_ABOVE_155 <= 1'b1;
    cyc(1);
    TEMP_ABOVE_155 <= 1'b0;
    cyc(4);
    @(negedge MCLK);
    chk("ote_hb", HB_ENABLE, HB_NONE);
    chk("ote_sd", FAULT_SHUTDOWN_N_OE, 4'h0);
    clr;
    chk("ote_clear", HB_ENABLE, HB_ALL);
    @(posedge MCLK);
    GATE_DRIVE_SUPPLY_OK <= 4'hE;
    cyc(2);
    @(negedge MCLK);
    chk("uv_hb", HB_ENABLE, HB_NONE);
    chk("uv_sd", FAULT_SHUTDOWN_N_OE, 4'h0);
    @(posedge MCLK);
    GATE_DRIVE_SUPPLY_OK <= HB_ALL;
    cyc(3);
    @(negedge MCLK);
    chk("uv_back", HB_ENABLE, HB_ALL);
    $display("test latch and supply done");
    end_of_test;
  end
endmodule // tb
